// >>> ara_pkg.sv
/*
 * Shared constants for the round assist unit: opcode bytes, field codes,
 * widths and the operation encoding.
 * Assumes the decoder hands over raw opcode bytes and prefix fields.
 */
package ara_pkg;
    localparam int VEC_W       = 256;
    localparam int LANE_W      = 128;
    localparam logic [7:0] OPC_ESC0     = 8'h0F;
    localparam logic [7:0] OPC_PFX_OPSZ = 8'h66;
    localparam logic [7:0] OPC_MAP_38   = 8'h38;
    localparam logic [7:0] OPC_MAP_3A   = 8'h3A;
    localparam logic [7:0] OPC_DEC      = 8'hDE;
    localparam logic [7:0] OPC_KGA      = 8'hDF;
    localparam logic [3:0] EXTRA_SPEC_RSVD = 4'hF;
    localparam logic [1:0] VEX_PP_66   = 2'h1;
    localparam logic [1:0] VEX_MAP_38  = 2'h2;
    localparam logic [1:0] VEX_MAP_3A  = 2'h3;

    typedef enum logic [1:0] {
        ARA_OP_NONE,
        ARA_OP_DEC,
        ARA_OP_KGA
    } ara_op_t;
endpackage

// >>> ara_unit.sv
/*
 * Round assist datapath: one inverse-cipher decryption round and the
 * key expansion assist, one pipeline stage, result registered.
 * Assumes the decoder presents one instruction per cycle with its
 * operands already read; memory operands arrive as plain 128-bit data.
 */
`timescale 1ns/1ps

module ara_unit (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         issue_valid_i,
    input  wire logic         vex_form_i,
    input  wire logic [7:0]   legacy_prefix_i,
    input  wire logic [7:0]   legacy_escape_i,
    input  wire logic [7:0]   legacy_map_i,
    input  wire logic [1:0]   vex_pp_i,
    input  wire logic [1:0]   vex_map_i,
    input  wire logic [7:0]   opcode_i,
    input  wire logic [3:0]   extra_register_specifier_field_i,
    input  wire logic [7:0]   immediate_byte_i,
    input  wire logic         cipher_flag_i,
    input  wire logic         wide_flag_i,
    input  wire logic [255:0] dest_old_i,
    input  wire logic [127:0] src_a_i,
    input  wire logic [127:0] src_b_i,
    output logic              done_o,
    output logic              undefined_opcode_fault_o,
    output logic              write_en_o,
    output logic [255:0]      result_o
);

    // ************************************************************
    // AES primitives
    // ************************************************************
    function automatic logic [7:0] xt(input logic [7:0] b);
        xt = {b[6:0], 1'b0} ^ (b[7] ? 8'h1B : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = xt(x);
        end
        gmul = p;
    endfunction

    // Inverse in GF(2^8) by a^254; small area matters less than a table here.
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 254; i++) begin
            r = gmul(r, a);
        end
        ginv = r;
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] v;
        logic [7:0] s;
        v = ginv(a);
        for (int i = 0; i < 8; i++) begin
            s[i] = v[i] ^ v[(i + 4) % 8] ^ v[(i + 5) % 8] ^ v[(i + 6) % 8]
                   ^ v[(i + 7) % 8];
        end
        sbox = s ^ 8'h63;
    endfunction

    function automatic logic [7:0] inv_sbox(input logic [7:0] a);
        logic [7:0] s;
        logic [7:0] v;
        s = a ^ 8'h63;
        for (int i = 0; i < 8; i++) begin
            v[i] = s[(i + 2) % 8] ^ s[(i + 5) % 8] ^ s[(i + 7) % 8];
        end
        inv_sbox = ginv(v);
    endfunction

    function automatic logic [31:0] sub_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            sub_word[8*i +: 8] = sbox(w[8*i +: 8]);
        end
    endfunction

    // Byte 0 of the state is bits 7:0; column c holds bytes 4c..4c+3.
    function automatic logic [7:0] sbyte(input logic [127:0] s, input int idx);
        sbyte = s[8*idx +: 8];
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    logic    legacy_ok;
    logic    vex_ok;
    ara_pkg::ara_op_t op_sel;
    logic    fault_now;

    always_comb begin
        op_sel    = ara_pkg::ARA_OP_NONE;
        fault_now = 1'b0;
        legacy_ok = (legacy_prefix_i == ara_pkg::OPC_PFX_OPSZ)
                    && (legacy_escape_i == ara_pkg::OPC_ESC0);
        vex_ok    = (vex_pp_i == ara_pkg::VEX_PP_66);
        if (!vex_form_i && legacy_ok) begin
            if (legacy_map_i == ara_pkg::OPC_MAP_38 && opcode_i == ara_pkg::OPC_DEC) begin
                op_sel = ara_pkg::ARA_OP_DEC;
            end else if (legacy_map_i == ara_pkg::OPC_MAP_3A
                         && opcode_i == ara_pkg::OPC_KGA) begin
                op_sel = ara_pkg::ARA_OP_KGA;
            end
        end else if (vex_form_i && vex_ok) begin
            if (vex_map_i == ara_pkg::VEX_MAP_38 && opcode_i == ara_pkg::OPC_DEC) begin
                op_sel = ara_pkg::ARA_OP_DEC;
            end else if (vex_map_i == ara_pkg::VEX_MAP_3A && opcode_i == ara_pkg::OPC_KGA) begin
                op_sel = ara_pkg::ARA_OP_KGA;
            end
        end
        if (op_sel != ara_pkg::ARA_OP_NONE) begin
            if (!cipher_flag_i || (vex_form_i && !wide_flag_i)) begin
                fault_now = 1'b1;
            end
            // Only the key assist reserves the specifier; decrypt uses it as the state register.
            if (vex_form_i && op_sel == ara_pkg::ARA_OP_KGA
                && extra_register_specifier_field_i != ara_pkg::EXTRA_SPEC_RSVD) begin
                fault_now = 1'b1;
            end
        end
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    logic [127:0] isr;
    logic [127:0] isb;
    logic [127:0] imc;
    logic [127:0] dec_res;
    logic [127:0] kga_res;
    logic [31:0]  rc;
    logic [31:0]  sw1;
    logic [31:0]  sw3;

    // Operand A is the state (reg field in legacy, specifier in prefixed form),
    // operand B the key from register or memory; the decoder routes both.
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                isr[8*(4*c + r) +: 8] = sbyte(src_a_i, 4*((c + 4 - r) % 4) + r);
            end
        end
        for (int i = 0; i < 16; i++) begin
            isb[8*i +: 8] = inv_sbox(isr[8*i +: 8]);
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                imc[8*(4*c + r) +: 8] = gmul(sbyte(isb, 4*c + r), 8'h0E)
                    ^ gmul(sbyte(isb, 4*c + (r + 1) % 4), 8'h0B)
                    ^ gmul(sbyte(isb, 4*c + (r + 2) % 4), 8'h0D)
                    ^ gmul(sbyte(isb, 4*c + (r + 3) % 4), 8'h09);
            end
        end
        dec_res = imc ^ src_b_i;
        rc  = {24'h000000, immediate_byte_i};
        sw1 = sub_word(src_b_i[63:32]);
        sw3 = sub_word(src_b_i[127:96]);
        kga_res = {{sw3[7:0], sw3[31:8]} ^ rc, sw3,
                   {sw1[7:0], sw1[31:8]} ^ rc, sw1};
    end

    // ************************************************************
    // Result stage
    // ************************************************************
    logic         next_done;
    logic         next_fault;
    logic         next_we;
    logic [255:0] next_result;

    always_comb begin
        next_done   = issue_valid_i;
        next_fault  = 1'b0;
        next_we     = 1'b0;
        next_result = result_o;
        if (issue_valid_i) begin
            if (op_sel == ara_pkg::ARA_OP_NONE || fault_now) begin
                next_fault = 1'b1;
            end else begin
                next_we = 1'b1;
                next_result[ara_pkg::LANE_W-1:0] = (op_sel == ara_pkg::ARA_OP_DEC)
                                                   ? dec_res : kga_res;
                next_result[ara_pkg::VEC_W-1:ara_pkg::LANE_W] = vex_form_i
                    ? 128'h0
                    : dest_old_i[ara_pkg::VEC_W-1:ara_pkg::LANE_W];
            end
        end
    end

    // No floating-point status leaves this unit; memory faults come from the load path.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o                   <= 1'b0;
            undefined_opcode_fault_o <= 1'b0;
            write_en_o               <= 1'b0;
            result_o                 <= '0;
        end else begin
            done_o                   <= next_done;
            undefined_opcode_fault_o <= next_fault;
            write_en_o               <= next_we;
            result_o                 <= next_result;
        end
    end

endmodule

// >>> ara_issuer.sv
/*
 * Issuer model: encodes the chosen operation into both the legacy and
 * the prefixed decoder fields of the round assist unit.
 * Assumes the bench picks the form and the operation each cycle.
 */
`timescale 1ns/1ps
module ara_issuer (
    input  wire logic       kga_i,
    output logic [7:0]      pfx_o,
    output logic [7:0]      esc_o,
    output logic [7:0]      map_o,
    output logic [1:0]      pp_o,
    output logic [1:0]      vmap_o,
    output logic [7:0]      opc_o
);
    // Only middle rounds are issued here; the final round goes elsewhere.
    assign opc_o  = kga_i ? ara_pkg::OPC_KGA : ara_pkg::OPC_DEC;
    assign pfx_o  = ara_pkg::OPC_PFX_OPSZ;
    assign esc_o  = ara_pkg::OPC_ESC0;
    assign map_o  = kga_i ? ara_pkg::OPC_MAP_3A : ara_pkg::OPC_MAP_38;
    assign pp_o   = ara_pkg::VEX_PP_66;
    assign vmap_o = kga_i ? ara_pkg::VEX_MAP_3A : ara_pkg::VEX_MAP_38;
endmodule

// >>> ara_unit_props.sv
/*
 * Checker for the round assist unit, bound to its ports.
 * Assumes one-cycle answers as handed over for the unit.
 */
`timescale 1ns/1ps
module ara_unit_props (
    input wire logic         mclk_i,
    input wire logic         rstn_i,
    input wire logic         issue_valid_i,
    input wire logic         vex_form_i,
    input wire logic [7:0]   opcode_i,
    input wire logic [3:0]   extra_register_specifier_field_i,
    input wire logic [7:0]   immediate_byte_i,
    input wire logic         cipher_flag_i,
    input wire logic         wide_flag_i,
    input wire logic [255:0] dest_old_i,
    input wire logic         done_o,
    input wire logic         undefined_opcode_fault_o,
    input wire logic         write_en_o,
    input wire logic [255:0] result_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_answer;
        ##1 (done_o && (write_en_o != undefined_opcode_fault_o));
    endsequence
    sequence s_kga_done;
        write_en_o && ($past(opcode_i) == ara_pkg::OPC_KGA);
    endsequence
    a_done_follows: assert property (issue_valid_i |-> s_answer) else $error("no answer");
    a_no_spurious: assert property (!issue_valid_i |=> !done_o && !write_en_o) else $error("pulse");
    a_vex_zero: assert property (write_en_o && $past(vex_form_i) |-> result_o[255:128] == '0)
        else $error("upper not zero");
    a_legacy_keep: assert property (write_en_o && !$past(vex_form_i)
        |-> result_o[255:128] == $past(dest_old_i[255:128])) else $error("upper lost");
    a_spec_fault: assert property (issue_valid_i && vex_form_i && opcode_i == ara_pkg::OPC_KGA
        && extra_register_specifier_field_i != 4'hF |=> undefined_opcode_fault_o) else $error("spec");
    a_cipher_need: assert property (issue_valid_i && !cipher_flag_i |=> !write_en_o)
        else $error("cipher flag");
    a_wide_need: assert property (issue_valid_i && vex_form_i && !wide_flag_i |=> !write_en_o)
        else $error("wide flag");
    a_result_hold: assert property (!write_en_o |-> $stable(result_o)) else $error("result moved");
    a_round_constant_low: assert property (s_kga_done |-> result_o[63:32] ==
        ({result_o[7:0], result_o[31:8]} ^ {24'h0, $past(immediate_byte_i)})) else $error("word 1");
    a_round_constant_high: assert property (s_kga_done |-> result_o[127:96] ==
        ({result_o[71:64], result_o[95:72]} ^ {24'h0, $past(immediate_byte_i)})) else $error("word 3");
endmodule
bind ara_unit ara_unit_props u_props (.*);

// >>> ara_unit_bench.sv
/*
 * Self-checking bench for the round assist unit with the issuer model.
 * Assumes the unit answers exactly one cycle after each issue.
 */
`timescale 1ns/1ps
module ara_unit_bench;
    logic         mclk_i = 1'b0;
    logic         rstn_i = 1'b0;
    logic         issue_valid_i = 1'b0;
    logic         vex_form_i = 1'b0;
    logic         kga = 1'b0;
    logic [3:0]   extra_register_specifier_field_i = 4'hF;
    logic [7:0]   immediate_byte_i = 8'h00;
    logic         cipher_flag_i = 1'b1;
    logic         wide_flag_i = 1'b1;
    logic [255:0] dest_old_i = {4{64'hDEAD_BEEF_0BAD_F00D}};
    logic [127:0] src_a_i = '0;
    logic [127:0] src_b_i = '0;
    logic [7:0]   pfx, esc, map, opc;
    logic [1:0]   pp, vmap;
    logic         done_o, undefined_opcode_fault_o, write_en_o;
    logic [255:0] result_o;
    logic [127:0] key = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    int           n_fail = 0;
    int           n_checks = 0;
    int           cyc = 0;
    ara_issuer enc (.kga_i(kga), .pfx_o(pfx), .esc_o(esc), .map_o(map), .pp_o(pp),
        .vmap_o(vmap), .opc_o(opc));
    ara_unit dut (.*, .legacy_prefix_i(pfx), .legacy_escape_i(esc), .legacy_map_i(map),
        .vex_pp_i(pp), .vex_map_i(vmap), .opcode_i(opc));
    // ***************************************************************
    // Shared tasks
    // ***************************************************************
    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic v, input logic k, input logic [127:0] a, b);
        @(posedge mclk_i);
        #1;
        issue_valid_i = 1'b1;
        vex_form_i = v;
        kga = k;
        src_a_i = a;
        src_b_i = b;
        @(posedge mclk_i);
        #1;
        issue_valid_i = 1'b0;
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    // A zero state inverts to 0x52 in every byte, which column mixing keeps.
    task automatic t_dec();
        wide_flag_i = 1'b0;
        issue(1'b0, 1'b0, '0, key);
        check({done_o, write_en_o}, 2'b11);
        check(result_o, {dest_old_i[255:128], {16{8'h52}} ^ key});
        wide_flag_i = 1'b1;
        issue(1'b1, 1'b0, {16{8'h01}}, key);
        check(result_o, {128'h0, {16{8'h09}} ^ key});
    endtask
    task automatic t_kga();
        logic [31:0] rc;
        for (int i = 0; i < 4; i++) begin
            immediate_byte_i = 8'h1B + 8'(i * 64);
            rc = {24'h0, immediate_byte_i};
            issue(i[0], 1'b1, key, 128'h0000_0000_0000_0000_0000_0001_0000_0000);
            check(result_o, {i[0] ? 128'h0 : dest_old_i[255:128], 32'h63636363 ^ rc,
                32'h63636363, 32'h7C636363 ^ rc, 32'h6363637C});
        end
    endtask
    task automatic t_fault();
        logic [255:0] keep;
        keep = result_o;
        extra_register_specifier_field_i = 4'hE;
        issue(1'b1, 1'b1, '0, '0);
        check({done_o, undefined_opcode_fault_o, write_en_o}, 3'b110);
        check(result_o, keep);
        extra_register_specifier_field_i = 4'hF;
        wide_flag_i = 1'b0;
        issue(1'b1, 1'b0, '0, '0);
        check({undefined_opcode_fault_o, write_en_o}, 2'b10);
        wide_flag_i = 1'b1;
        cipher_flag_i = 1'b0;
        issue(1'b0, 1'b0, '0, '0);
        check({undefined_opcode_fault_o, write_en_o}, 2'b10);
        check(result_o, keep);
        cipher_flag_i = 1'b1;
        rstn_i = 1'b0;
        #1;
        check(result_o, '0);
        // Reset spans two edges so the checker sees the cleared result while disabled.
        repeat (2) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        issue(1'b1, 1'b0, '0, key);
        check(result_o, {128'h0, {16{8'h52}} ^ key});
    endtask
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // The ceiling sits far above the few dozen cycles the scenarios need.
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        t_dec();
        t_kga();
        t_fault();
        final_report();
    end
endmodule
